// ===== frrc_pkg.sv
// Package: register map, field layout, defaults and types of the frequency reference ramp block
package frrc_pkg;

  // ==========================================================
  // Widths
  localparam int FW = 16;
  localparam int PW = 11;
  localparam int TW = 16;
  localparam int AW = 12;
  localparam int CW = 48;
  localparam int SELW = 3;
  localparam int AUXW = 4;
  localparam int APPW = 3;
  localparam int PAIRW = 2;

  // ==========================================================
  // Register map (byte addresses)
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_FMAX = 8'h04;
  localparam logic [7:0] ADDR_LIMIT = 8'h08;
  localparam logic [7:0] ADDR_FMIN = 8'h0C;
  localparam logic [7:0] ADDR_KEYPAD = 8'h10;
  localparam logic [7:0] ADDR_COMM = 8'h14;
  localparam logic [7:0] ADDR_JOG = 8'h18;
  localparam logic [7:0] ADDR_JOGT = 8'h1C;
  localparam logic [7:0] ADDR_ESTOP = 8'h30;
  localparam logic [7:0] ADDR_STATUS = 8'h40;
  localparam logic [7:0] ADDR_OUTF = 8'h44;
  localparam logic [7:0] ADDR_REF = 8'h48;
  localparam logic [7:0] ADDR_COMM_RD = 8'h4C;
  localparam logic [7:0] ADDR_PIDMIN = 8'h50;
  localparam logic [3:0] PAIR_PAGE = 4'h2;
  localparam int PAGE_LSB = 4;
  localparam int PIDX_LSB = 2;
  localparam int HI_LSB = 16;

  // ==========================================================
  // Field positions
  localparam int CTRL_MAIN = 0;
  localparam int CTRL_ALT = 3;
  localparam int CTRL_COMBINE = 6;
  localparam int CTRL_AUX = 8;
  localparam int CTRL_INV = 12;
  localparam int CTRL_COMM_MEM = 13;
  localparam int CTRL_PID_SEL = 14;
  localparam int CTRL_MOTOR = 15;
  localparam int CTRL_TERM_EN = 16;
  localparam int CTRL_APP = 17;
  localparam int ST_CONFLICT = 0;
  localparam int ST_RANGE = 1;
  localparam int ST_ESTOP = 2;
  localparam int ST_COAST = 3;
  localparam int ST_RUN = 4;
  localparam int ST_PAIR = 5;
  localparam int ST_INIT = 7;

  // ==========================================================
  // Reset values, ranges and scales (0.01 Hz, 0.1 %, 0.1 s)
  localparam logic [FW-1:0] DEF_FMAX = 16'h1770;
  localparam logic [PW-1:0] DEF_UPPER = 11'h3E8;
  localparam logic [PW-1:0] DEF_LOWER = 11'h000;
  localparam logic [TW-1:0] DEF_TIME = 16'h0064;
  localparam logic [FW-1:0] DEF_JOG = 16'h0258;
  localparam logic [FW-1:0] FREQ_SET_MAX = 16'h9C40;
  localparam logic [FW-1:0] PCT_MIN = 16'h0001;
  localparam logic [FW-1:0] PCT_MAX = 16'h0442;
  localparam logic [FW-1:0] TIME_MIN = 16'h0001;
  localparam logic [FW-1:0] TIME_MAX = 16'hEA60;
  localparam logic [FW-1:0] JOGT_MAX = 16'h1770;
  localparam logic [PW-1:0] PCT_FULL = 11'h3E8;
  localparam logic [AW-1:0] AIN_FULL = 12'hFFF;
  localparam logic [PAIRW-1:0] PAIR_ONE = 2'h0;
  localparam logic [PAIRW-1:0] PAIR_FOUR = 2'h3;

  // ==========================================================
  // Timing
  localparam int CLK_PERIOD_NS = 5;
  localparam int TIME_UNIT_NS = 100_000_000;
  localparam int TIME_UNIT_CYC = (TIME_UNIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int UPDN_STEP_NS = 10_000;
  localparam int UPDN_CYC = (UPDN_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ==========================================================
  // Types
  typedef enum logic [2:0] {
    SRC_KEYPAD = 3'h0,
    SRC_AIN1 = 3'h1,
    SRC_UPDN = 3'h2,
    SRC_COMM = 3'h3,
    SRC_RSV4 = 3'h4,
    SRC_RSV5 = 3'h5,
    SRC_RTC = 3'h6,
    SRC_AIN2 = 3'h7
  } frrc_src_t;

  typedef enum logic [1:0] {
    ST_IDLE_S = 2'h0,
    ST_RUN_S = 2'h1,
    ST_ESTOP_S = 2'h3,
    ST_COAST_S = 2'h2
  } frrc_state_t;

endpackage : frrc_pkg

// ===== frrc_ramp_gen.sv
// Ramp generator: steps the output frequency one unit at a time toward its target
`timescale 1ns/100ps
module frrc_ramp_gen #(
  parameter int W = frrc_pkg::FW,
  parameter int CWID = frrc_pkg::CW
) (
  input logic clock,
  input logic rst,
  input logic [W-1:0] target,
  input logic [W-1:0] fmax,
  input logic [CWID-1:0] span_cyc,
  input logic load,
  input logic [W-1:0] load_val,
  input logic coast,
  output logic [W-1:0] freq
);
  import frrc_pkg::*;

  logic [CWID-1:0] acc_q;
  logic [CWID-1:0] acc_sum;
  logic moving;
  logic step;

  // ==========================================================
  // Rate accumulator
  // Adds fmax each cycle; a unit step per wrap of span gives fmax per full span.
  // Span can fall below fmax (1 for a zero emergency time); steps are then capped at one unit per cycle.
  assign moving = (freq != target);
  assign acc_sum = acc_q + CWID'(fmax);
  assign step = moving && (acc_sum >= span_cyc);

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      acc_q <= '0;
    end else if (coast || load || !moving) begin
      acc_q <= '0;
    end else if (step) begin
      acc_q <= acc_sum - span_cyc;
    end else begin
      acc_q <= acc_sum;
    end
  end

  // ==========================================================
  // Output frequency
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      freq <= '0;
    end else if (coast) begin
      freq <= '0;
    end else if (load) begin
      freq <= load_val;
    end else if (step && (freq < target)) begin
      freq <= W'(freq + 1'b1);
    end else if (step) begin
      freq <= W'(freq - 1'b1);
    end
  end

endmodule : frrc_ramp_gen

// ===== frrc_ref_ramp.sv
// Frequency reference selection, limiting and ramp control with APB register access
// Overview of operation
// - Combine mode 0 uses main source only; 1 adds main and alternative.
// - Combine mode 1 with equal main and alternative selections flags a source conflict.
// - Alternative keypad selection takes the speed-stage-0 frequency setting.
// - Source 7 scales analog input two to fmax, only when aux config is 0.
// - Read-only communication frequency shows the reference when a source is communication.
// - Communication memory 1 keeps the communication reference over power down.
// - PID floor during sleep is lower limit for selection 0, else 0 Hz.
// - Reference is capped at upper limit, 0.1 to 109.0 % of fmax.
// - Reference is floored at lower limit, 0.0 to 109.0 % of fmax.
// - Upper limit below lower limit raises the limit range error.
// - Limits apply for every reference source and mode, jog included.
// - Start with lower limit above 0 begins ramping from motor minimum frequency.
// - Ramp time is the time from zero to full fmax.
// - Two terminal bits select ramp pairs one to four.
// - Nonzero switch-over frequency picks pair one below it, pair four at or above.
// - Terminal ramp selection overrides switch-over frequency selection.
// - Jog uses jog frequency and jog ramp times.
// - Emergency stop input decelerates with emergency time and shows the indication.
// - Emergency stop holds until run command and emergency input are both removed.
// - Base block input turns output off at once; motor coasts.
// - Analog characteristic 0 maps span 0 to 100 %, 1 maps 100 to 0 %.
// - Changing application preset to 0 reloads 60 Hz two-wire defaults.
// - Source codes: keypad, analog one, up/down, comm, reserved, reserved, clock, analog two.
// - Up/down source rises with up input and falls with down input.
//
// The register offsets and register access over APB were left to the implementer.
`timescale 1ns/100ps
module frrc_ref_ramp #(
  parameter int unsigned TENTH_CYC = frrc_pkg::TIME_UNIT_CYC,
  parameter int unsigned UPDN_TICK = frrc_pkg::UPDN_CYC
) (
  input logic clock,
  input logic rst,
  input logic psel,
  input logic penable,
  input logic pwrite,
  input logic [7:0] paddr,
  input logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input logic run_cmd,
  input logic jog_cmd,
  input logic estop_in,
  input logic base_block_in,
  input logic ramp_sel_lo,
  input logic ramp_sel_hi,
  input logic up_in,
  input logic down_in,
  input logic power_down,
  input logic [frrc_pkg::AW-1:0] analog_in_one,
  input logic [frrc_pkg::AW-1:0] analog_in_two,
  input logic [frrc_pkg::FW-1:0] rtc_freq,
  output logic [frrc_pkg::FW-1:0] out_freq,
  output logic drive_on,
  output logic emergency_stop_indication,
  output logic source_conflict_error,
  output logic limit_range_error,
  output logic [frrc_pkg::FW-1:0] pid_min_freq
);
  import frrc_pkg::*;

  // ==========================================================
  // Declarations
  logic [SELW-1:0] main_sel_q;
  logic [SELW-1:0] alt_sel_q;
  logic combine_q;
  logic [AUXW-1:0] aux_cfg_q;
  logic inv_q;
  logic comm_mem_q;
  logic pid_sel_q;
  logic motor_q;
  logic term_en_q;
  logic [APPW-1:0] app_q;
  logic [FW-1:0] fmax1_q;
  logic [FW-1:0] fmax2_q;
  logic [FW-1:0] fmin1_q;
  logic [FW-1:0] fmin2_q;
  logic [PW-1:0] upper_q;
  logic [PW-1:0] lower_q;
  logic [FW-1:0] keypad_q;
  logic [FW-1:0] comm_q;
  logic [FW-1:0] jog_q;
  logic [TW-1:0] jog_acc_q;
  logic [TW-1:0] jog_dec_q;
  logic [TW-1:0] estop_t_q;
  logic [FW-1:0] sw_freq_q;
  logic [TW-1:0] acc_t [4];
  logic [TW-1:0] dec_t [4];
  logic init_done_q;
  logic [FW-1:0] updn_q;
  logic [15:0] updn_cnt_q;
  frrc_state_t state_q;
  frrc_state_t state_d;
  logic [FW-1:0] ref_q;
  logic [31:0] rdata_d;
  logic rd_ok;
  logic apb_wr;
  logic init_evt;
  logic [FW-1:0] fmax_f;
  logic [FW-1:0] fmin_f;
  logic [FW-1:0] upper_f;
  logic [FW-1:0] lower_f;
  logic [FW-1:0] main_f;
  logic [FW-1:0] alt_f;
  logic [FW:0] sum_f;
  logic [FW:0] base_f;
  logic [FW-1:0] ref_c;
  logic [FW-1:0] target;
  logic go;
  logic conflict;
  logic range_bad;
  logic speed_up;
  logic [PAIRW-1:0] pair;
  logic [TW-1:0] sel_time;
  logic [CW-1:0] span;
  logic ramp_load;
  logic updn_used;

  // ==========================================================
  // Helpers
  function automatic logic [FW-1:0] lim(input logic [FW-1:0] v, input logic [FW-1:0] lo,
                                        input logic [FW-1:0] hi);
    lim = (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction : lim

  function automatic logic [FW-1:0] pct_of(input logic [FW-1:0] fm, input logic [PW-1:0] pct);
    logic [FW+PW-1:0] p;
    p = (FW+PW)'(fm) * (FW+PW)'(pct);
    pct_of = FW'(p / (FW+PW)'(PCT_FULL));
  endfunction : pct_of

  function automatic logic [FW-1:0] ain_f(input logic [AW-1:0] a, input logic inv,
                                          input logic [FW-1:0] fm);
    logic [AW-1:0] v;
    logic [FW+AW-1:0] p;
    v = inv ? AW'(AIN_FULL - a) : a;
    p = (FW+AW)'(fm) * (FW+AW)'(v);
    ain_f = FW'(p / (FW+AW)'(AIN_FULL));
  endfunction : ain_f

  function automatic logic [FW-1:0] src_f(input logic [SELW-1:0] sel);
    unique case (frrc_src_t'(sel))
      SRC_KEYPAD: src_f = keypad_q;
      SRC_AIN1: src_f = ain_f(analog_in_one, inv_q, fmax_f);
      SRC_UPDN: src_f = updn_q;
      SRC_COMM: src_f = comm_q;
      SRC_RTC: src_f = rtc_freq;
      SRC_AIN2: src_f = (aux_cfg_q == '0) ? ain_f(analog_in_two, inv_q, fmax_f) : '0;
      SRC_RSV4, SRC_RSV5: src_f = '0;
    endcase
  endfunction : src_f

  // ==========================================================
  // APB slave: access phase is two cycles, pready registered
  assign apb_wr = psel && penable && pready && pwrite;
  assign init_evt = apb_wr && (paddr == ADDR_CTRL) && (pwdata[CTRL_APP +: APPW] == '0) && (app_q != '0);

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      pready <= 1'b0;
      prdata <= '0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && penable && !pready;
      prdata <= (psel && penable && !pready && !pwrite) ? rdata_d : '0;
      pslverr <= psel && penable && !pready && !rd_ok;
    end
  end

  always_comb begin
    rdata_d = '0;
    rd_ok = 1'b1;
    unique case (paddr)
      ADDR_CTRL: rdata_d = {12'h000, app_q, term_en_q, motor_q, pid_sel_q, comm_mem_q, inv_q,
                            aux_cfg_q, 1'b0, combine_q, alt_sel_q, main_sel_q};
      ADDR_FMAX: rdata_d = {fmax2_q, fmax1_q};
      ADDR_LIMIT: rdata_d = {5'h00, lower_q, 5'h00, upper_q};
      ADDR_FMIN: rdata_d = {fmin2_q, fmin1_q};
      ADDR_KEYPAD: rdata_d = {16'h0000, keypad_q};
      ADDR_COMM: rdata_d = {16'h0000, comm_q};
      ADDR_JOG: rdata_d = {16'h0000, jog_q};
      ADDR_JOGT: rdata_d = {jog_dec_q, jog_acc_q};
      ADDR_ESTOP: rdata_d = {sw_freq_q, estop_t_q};
      ADDR_STATUS: rdata_d = {24'h00_0000, init_done_q, pair, state_q == ST_RUN_S,
                              state_q == ST_COAST_S, emergency_stop_indication,
                              limit_range_error, source_conflict_error};
      ADDR_OUTF: rdata_d = {16'h0000, out_freq};
      ADDR_REF: rdata_d = {16'h0000, ref_q};
      ADDR_COMM_RD: rdata_d = {16'h0000, (main_sel_q == SRC_COMM || alt_sel_q == SRC_COMM) ? comm_q
                                         : 16'h0000};
      ADDR_PIDMIN: rdata_d = {16'h0000, pid_min_freq};
      default: begin
        if (paddr[7:PAGE_LSB] == PAIR_PAGE) begin
          rdata_d = {dec_t[paddr[PAGE_LSB-1:PIDX_LSB]], acc_t[paddr[PAGE_LSB-1:PIDX_LSB]]};
        end else begin
          rd_ok = 1'b0;
        end
      end
    endcase
  end

  // ==========================================================
  // Configuration registers
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      main_sel_q <= '0;
      alt_sel_q <= '0;
      combine_q <= 1'b0;
      aux_cfg_q <= '0;
      inv_q <= 1'b0;
      comm_mem_q <= 1'b0;
      pid_sel_q <= 1'b0;
      motor_q <= 1'b0;
      term_en_q <= 1'b0;
      app_q <= '0;
      fmax1_q <= DEF_FMAX;
      fmax2_q <= DEF_FMAX;
      fmin1_q <= '0;
      fmin2_q <= '0;
      upper_q <= DEF_UPPER;
      lower_q <= DEF_LOWER;
      keypad_q <= '0;
      jog_q <= DEF_JOG;
      jog_acc_q <= DEF_TIME;
      jog_dec_q <= DEF_TIME;
      estop_t_q <= DEF_TIME;
      sw_freq_q <= '0;
      init_done_q <= 1'b0;
    end else if (init_evt) begin
      app_q <= '0;
      main_sel_q <= '0;
      alt_sel_q <= '0;
      combine_q <= 1'b0;
      fmax1_q <= DEF_FMAX;
      fmax2_q <= DEF_FMAX;
      upper_q <= DEF_UPPER;
      lower_q <= DEF_LOWER;
      jog_q <= DEF_JOG;
      jog_acc_q <= DEF_TIME;
      jog_dec_q <= DEF_TIME;
      estop_t_q <= DEF_TIME;
      sw_freq_q <= '0;
      init_done_q <= 1'b1;
    end else if (apb_wr) begin
      unique case (paddr)
        ADDR_CTRL: begin
          main_sel_q <= pwdata[CTRL_MAIN +: SELW];
          alt_sel_q <= pwdata[CTRL_ALT +: SELW];
          combine_q <= pwdata[CTRL_COMBINE];
          aux_cfg_q <= pwdata[CTRL_AUX +: AUXW];
          inv_q <= pwdata[CTRL_INV];
          comm_mem_q <= pwdata[CTRL_COMM_MEM];
          pid_sel_q <= pwdata[CTRL_PID_SEL];
          motor_q <= pwdata[CTRL_MOTOR];
          term_en_q <= pwdata[CTRL_TERM_EN];
          app_q <= pwdata[CTRL_APP +: APPW];
          init_done_q <= 1'b0;
        end
        ADDR_FMAX: begin
          fmax1_q <= pwdata[FW-1:0];
          fmax2_q <= pwdata[HI_LSB +: FW];
        end
        ADDR_LIMIT: begin
          upper_q <= PW'(lim(pwdata[FW-1:0], PCT_MIN, PCT_MAX));
          lower_q <= PW'(lim(FW'(pwdata[HI_LSB +: PW]), '0, PCT_MAX));
        end
        ADDR_FMIN: begin
          fmin1_q <= pwdata[FW-1:0];
          fmin2_q <= pwdata[HI_LSB +: FW];
        end
        ADDR_KEYPAD: keypad_q <= lim(pwdata[FW-1:0], '0, FREQ_SET_MAX);
        ADDR_JOG: jog_q <= lim(pwdata[FW-1:0], '0, FREQ_SET_MAX);
        ADDR_JOGT: begin
          jog_acc_q <= lim(pwdata[FW-1:0], TIME_MIN, JOGT_MAX);
          jog_dec_q <= lim(pwdata[HI_LSB +: FW], TIME_MIN, JOGT_MAX);
        end
        ADDR_ESTOP: begin
          estop_t_q <= lim(pwdata[FW-1:0], '0, TIME_MAX);
          sw_freq_q <= lim(pwdata[HI_LSB +: FW], '0, FREQ_SET_MAX);
        end
        default: ;
      endcase
    end
  end

  // Ramp time pairs, one per entry
  for (genvar i = 0; i < 4; i++) begin : g_pair
    always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
        acc_t[i] <= DEF_TIME;
        dec_t[i] <= DEF_TIME;
      end else if (init_evt) begin
        acc_t[i] <= DEF_TIME;
        dec_t[i] <= DEF_TIME;
      end else if (apb_wr && paddr[7:PAGE_LSB] == PAIR_PAGE && paddr[PAGE_LSB-1:PIDX_LSB] == PAIRW'(i)) begin
        acc_t[i] <= lim(pwdata[FW-1:0], TIME_MIN, TIME_MAX);
        dec_t[i] <= lim(pwdata[HI_LSB +: FW], TIME_MIN, TIME_MAX);
      end
    end
  end

  // ==========================================================
  // Communication reference; a bus write wins over power down
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      comm_q <= '0;
    end else if (apb_wr && paddr == ADDR_COMM) begin
      comm_q <= lim(pwdata[FW-1:0], '0, FREQ_SET_MAX);
    end else if (power_down && !comm_mem_q) begin
      comm_q <= '0;
    end
  end

  // ==========================================================
  // Up/down reference, one unit per tick while an input is held
  assign updn_used = (main_sel_q == SRC_UPDN) || (combine_q && alt_sel_q == SRC_UPDN);

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      updn_cnt_q <= '0;
      updn_q <= '0;
    end else if (updn_cnt_q >= 16'(UPDN_TICK - 1)) begin
      updn_cnt_q <= '0;
      if (updn_used && up_in && !down_in && updn_q < upper_f) begin
        updn_q <= FW'(updn_q + 1'b1);
      end else if (updn_used && down_in && !up_in && updn_q != '0) begin
        updn_q <= FW'(updn_q - 1'b1);
      end
    end else begin
      updn_cnt_q <= 16'(updn_cnt_q + 1'b1);
    end
  end

  // ==========================================================
  // Reference path
  assign fmax_f = motor_q ? fmax2_q : fmax1_q;
  assign fmin_f = motor_q ? fmin2_q : fmin1_q;
  assign upper_f = pct_of(fmax_f, upper_q);
  assign lower_f = pct_of(fmax_f, lower_q);
  assign main_f = src_f(main_sel_q);
  assign alt_f = src_f(alt_sel_q);
  assign sum_f = {1'b0, main_f} + (combine_q ? {1'b0, alt_f} : '0);
  assign base_f = jog_cmd ? {1'b0, jog_q} : sum_f;

  // When the limits cross, a value above upper takes upper and any other takes lower; the range error reports that case
  always_comb begin
    if (base_f > {1'b0, upper_f}) begin
      ref_c = upper_f;
    end else if (base_f < {1'b0, lower_f}) begin
      ref_c = lower_f;
    end else begin
      ref_c = FW'(base_f);
    end
  end

  assign conflict = combine_q && (main_sel_q == alt_sel_q);
  assign range_bad = upper_q < lower_q;

  // ==========================================================
  // Run state machine
  assign go = run_cmd || jog_cmd;

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ST_IDLE_S: begin
        if (base_block_in) state_d = ST_COAST_S;
        else if (estop_in && go) state_d = ST_ESTOP_S;
        else if (go && !conflict && !range_bad) state_d = ST_RUN_S;
      end
      ST_RUN_S: begin
        if (base_block_in) state_d = ST_COAST_S;
        else if (estop_in) state_d = ST_ESTOP_S;
        else if (!go && out_freq == '0) state_d = ST_IDLE_S;
      end
      ST_ESTOP_S: begin
        if (base_block_in) state_d = ST_COAST_S;
        else if (!go && !estop_in && out_freq == '0) state_d = ST_IDLE_S;
      end
      ST_COAST_S: begin
        if (!base_block_in) state_d = ST_IDLE_S;
      end
    endcase
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state_q <= ST_IDLE_S;
    end else begin
      state_q <= state_d;
    end
  end

  assign target = (state_q == ST_RUN_S && go && !conflict) ? ref_c : '0;
  assign ramp_load = (state_q == ST_IDLE_S) && (state_d == ST_RUN_S) && (lower_q != '0);

  // ==========================================================
  // Ramp time selection
  assign speed_up = target > out_freq;

  always_comb begin
    if (term_en_q) begin
      pair = {ramp_sel_hi, ramp_sel_lo};
    end else if (sw_freq_q != '0 && out_freq >= sw_freq_q) begin
      pair = PAIR_FOUR;
    end else begin
      pair = PAIR_ONE;
    end
  end

  always_comb begin
    if (state_q == ST_ESTOP_S) begin
      sel_time = estop_t_q;
    end else if (jog_cmd) begin
      sel_time = speed_up ? jog_acc_q : jog_dec_q;
    end else begin
      sel_time = speed_up ? acc_t[pair] : dec_t[pair];
    end
  end

  // A zero emergency time still costs one cycle per unit
  assign span = (sel_time == '0) ? CW'(1) : CW'(sel_time) * CW'(TENTH_CYC);

  frrc_ramp_gen #(
    .W(FW),
    .CWID(CW)
  ) u_ramp (
    .clock(clock),
    .rst(rst),
    .target(target),
    .fmax(fmax_f),
    .span_cyc(span),
    .load(ramp_load),
    .load_val((fmin_f < ref_c) ? fmin_f : ref_c),
    .coast(base_block_in),
    .freq(out_freq)
  );

  // ==========================================================
  // Registered status outputs
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      drive_on <= 1'b0;
      emergency_stop_indication <= 1'b0;
      source_conflict_error <= 1'b0;
      limit_range_error <= 1'b0;
      pid_min_freq <= '0;
      ref_q <= '0;
    end else begin
      drive_on <= (state_d == ST_RUN_S) || (state_d == ST_ESTOP_S);
      emergency_stop_indication <= (state_d == ST_ESTOP_S);
      source_conflict_error <= conflict;
      limit_range_error <= range_bad;
      pid_min_freq <= pid_sel_q ? '0 : lower_f;
      ref_q <= ref_c;
    end
  end

endmodule : frrc_ref_ramp

// ===== frrc_ref_ramp_asserts.sv
// Checker: bus timing and stop/coast properties of the reference ramp block
`timescale 1ns/100ps
module frrc_ref_ramp_asserts #(
  parameter int unsigned TENTH_CYC = 1,
  parameter int unsigned UPDN_TICK = 1
) (
  input logic clock,
  input logic rst,
  input logic psel,
  input logic penable,
  input logic pready,
  input logic pslverr,
  input logic [31:0] prdata,
  input logic run_cmd,
  input logic estop_in,
  input logic base_block_in,
  input logic [frrc_pkg::FW-1:0] out_freq,
  input logic drive_on,
  input logic emergency_stop_indication
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  // ==========================================================
  // Bus
  a_ready_pulse: assert property (pready |=> !pready) else $error("pready too long");
  a_access_time: assert property ($rose(penable) && psel |-> !pready ##1 pready) else $error("access length");
  a_err_ready: assert property (pslverr |-> pready) else $error("pslverr alone");
  a_rdata_idle: assert property (!pready |-> prdata == 0) else $error("prdata not idle");
  // ==========================================================
  // Stop and coast
  a_block_zero: assert property (base_block_in |=> out_freq == 0) else $error("coast freq");
  a_block_off: assert property (base_block_in |=> !drive_on) else $error("coast drive");
  a_stop_drive: assert property (emergency_stop_indication |-> drive_on) else $error("stop drive");
  a_stop_entry: assert property (estop_in && drive_on && !base_block_in |=> emergency_stop_indication)
    else $error("stop entry");
  a_stop_hold: assert property (emergency_stop_indication && (run_cmd || estop_in) && !base_block_in
    |=> emergency_stop_indication) else $error("stop left early");
  c_stop_held: cover property (emergency_stop_indication && run_cmd && !estop_in);
  c_bus_error: cover property (pslverr);
  c_coast: cover property (base_block_in && out_freq != 0);
endmodule : frrc_ref_ramp_asserts

bind frrc_ref_ramp frrc_ref_ramp_asserts #(.TENTH_CYC(TENTH_CYC), .UPDN_TICK(UPDN_TICK)) u_frrc_ref_ramp_asserts (
  .clock, .rst, .psel, .penable, .pready, .pslverr, .prdata, .run_cmd, .estop_in, .base_block_in,
  .out_freq, .drive_on, .emergency_stop_indication);

// ===== frrc_term_model.sv
// Far-side model: analog terminals and clock-source reference
`timescale 1ns/100ps
module frrc_term_model (
  input logic [frrc_pkg::AW-1:0] level,
  output logic [frrc_pkg::AW-1:0] analog_in_one,
  output logic [frrc_pkg::AW-1:0] analog_in_two,
  output logic [frrc_pkg::FW-1:0] rtc_freq
);
  // Both inputs share one level; sources are told apart by selection
  assign analog_in_one = level;
  assign analog_in_two = level;
  assign rtc_freq = {4'h0, level};
endmodule : frrc_term_model

// ===== tb_frrc_ref_ramp.sv
// Testbench: reference selection, limits, ramp, stop and coast
`timescale 1ns/100ps
module tb_frrc_ref_ramp;
  import frrc_pkg::*;
  typedef struct {logic [15:0] ctrl, kp, comm; logic [31:0] lim; logic [11:0] ain;
    logic [15:0] refv; logic [1:0] err;} frrc_row_t;
  logic clock = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, run_cmd = 0, jog_cmd = 0, estop_in = 0;
  logic base_block_in = 0, ramp_sel_lo = 0, ramp_sel_hi = 0, up_in = 0, down_in = 0, power_down = 0, er;
  logic [7:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd;
  logic pready, pslverr, drive_on, emergency_stop_indication, source_conflict_error, limit_range_error;
  logic [11:0] level = 0, analog_in_one, analog_in_two;
  logic [15:0] rtc_freq, out_freq, pid_min_freq;
  int failures = 0, checks = 0;
  frrc_row_t rows[9] = '{
    '{16'h0000, 16'h0BB8, 16'h0000, 32'h0000_03E8, 12'h000, 16'h0BB8, 2'h0},
    '{16'h0000, 16'h0FA0, 16'h0000, 32'h0000_01F4, 12'h000, 16'h0BB8, 2'h0},
    '{16'h0000, 16'h01F4, 16'h0000, 32'h00C8_03E8, 12'h000, 16'h04B0, 2'h0},
    '{16'h0043, 16'h03E8, 16'h07D0, 32'h0000_03E8, 12'h000, 16'h0BB8, 2'h0},
    '{16'h005B, 16'h0000, 16'h03E8, 32'h0000_03E8, 12'h000, 16'h0000, 2'h1},
    '{16'h0000, 16'h0BB8, 16'h0000, 32'h00C8_0064, 12'h000, 16'h0000, 2'h2},
    '{16'h0007, 16'h0000, 16'h0000, 32'h0000_03E8, 12'hFFF, 16'h1770, 2'h0},
    '{16'h1001, 16'h0000, 16'h0000, 32'h0000_03E8, 12'hFFF, 16'h0000, 2'h0},
    '{16'h0006, 16'h0000, 16'h0000, 32'h0000_03E8, 12'h123, 16'h0123, 2'h0}};
  frrc_ref_ramp #(.TENTH_CYC(100), .UPDN_TICK(4)) u_frrc_ref_ramp (.*);
  frrc_term_model u_frrc_term_model (.*);
  always #2.5 clock = ~clock;
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e) begin
      failures++;
      $display("wrong value at %0t: %h expected %h", $time, s, e);
    end
  endtask : chk
  task automatic close_out;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : close_out
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clock);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1;
    for (n = 0; n < 20 && pready !== 1'b1; n++) @(posedge clock);
    if (n == 20) failures++;
    rd = prdata;
    er = pslverr;
    psel <= 0;
    penable <= 0;
    if (n == 20) close_out();
  endtask : apb
  task automatic wait_out(input logic [15:0] v);
    int n;
    for (n = 0; n < 3000 && out_freq !== v; n++) @(posedge clock);
    chk(32'(out_freq), 32'(v));
    if (n == 3000) close_out();
  endtask : wait_out
  initial begin
    repeat (16) @(posedge clock);
    rst <= 0;
    apb(0, ADDR_FMAX, 0);
    chk(rd, 32'h1770_1770);
    apb(0, ADDR_LIMIT, 0);
    chk(rd, 32'h0000_03E8);
    apb(0, 8'h60, 0);
    chk({rd[30:0], er}, 32'h0000_0001);
    $display("test reset done");
    foreach (rows[i]) begin
      apb(1, ADDR_CTRL, 32'(rows[i].ctrl));
      apb(1, ADDR_KEYPAD, 32'(rows[i].kp));
      apb(1, ADDR_COMM, 32'(rows[i].comm));
      apb(1, ADDR_LIMIT, rows[i].lim);
      level <= rows[i].ain;
      repeat (4) @(posedge clock);
      apb(0, ADDR_REF, 0);
      chk(32'({limit_range_error, source_conflict_error}), 32'(rows[i].err));
      if (!rows[i].err) chk(rd, 32'(rows[i].refv));
      chk(32'(pid_min_freq), 32'(DEF_FMAX) * rows[i].lim[26:16] / PCT_FULL);
      $display("test row %0d done", i);
    end
    apb(1, ADDR_CTRL, 32'h0000_0003);
    apb(1, ADDR_COMM, 32'h0000_0BB8);
    apb(0, ADDR_COMM_RD, 0);
    chk(rd, 32'h0000_0BB8);
    power_down <= 1;
    apb(0, ADDR_COMM_RD, 0);
    chk(rd, 32'h0000_0000);
    power_down <= 0;
    $display("test comm done");
    apb(1, ADDR_CTRL, 32'h0001_0000);
    apb(1, ADDR_KEYPAD, 32'h0000_003C);
    run_cmd <= 1;
    ramp_sel_hi <= 1;
    wait_out(16'h003C);
    chk(32'(drive_on), 1);
    apb(0, ADDR_STATUS, 0);
    chk(rd, 32'h0000_0050);
    estop_in <= 1;
    wait_out(16'h0000);
    chk(32'(emergency_stop_indication), 1);
    estop_in <= 0;
    repeat (4) @(posedge clock);
    chk(32'(emergency_stop_indication), 1);
    run_cmd <= 0;
    repeat (4) @(posedge clock);
    chk(32'(emergency_stop_indication), 0);
    run_cmd <= 1;
    wait_out(16'h003C);
    jog_cmd <= 1;
    wait_out(16'h0258);
    base_block_in <= 1;
    repeat (2) @(posedge clock);
    chk({15'h0000, drive_on, out_freq}, 32'h0000_0000);
    $display("test ramp stop coast done");
    close_out();
  end
endmodule : tb_frrc_ref_ramp
